// *** otg_irq_pkg.sv ***
// Package for the OTG edge interrupt latch: register map, bit positions, timing.
// Assumes a 20 MHz system clock and a plain address/strobe register port.
package otg_irq_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned REG_W = 16;

	// Register word addresses (status, set and clear aliases, timer control)
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h0378;
	localparam logic [ADDR_W-1:0] LATCH_SET_ADDR = 12'h037c;
	localparam logic [ADDR_W-1:0] LATCH_CLR_ADDR = 12'h037e;
	localparam logic [ADDR_W-1:0] FALL_SET_ADDR = 12'h0380;
	localparam logic [ADDR_W-1:0] FALL_CLR_ADDR = 12'h0382;
	localparam logic [ADDR_W-1:0] RISE_SET_ADDR = 12'h0384;
	localparam logic [ADDR_W-1:0] RISE_CLR_ADDR = 12'h0386;
	localparam logic [ADDR_W-1:0] TIMER_CTRL_ADDR = 12'h0390;

	// Bit positions
	localparam int unsigned BIT_VBUS_VALID = 0;
	localparam int unsigned BIT_SESSION_VALID = 1;
	localparam int unsigned BIT_DPLUS_SRP = 2;
	localparam int unsigned BIT_ROLE_SENSE = 3;
	localparam int unsigned BIT_REMOTE_CONNECT = 4;
	localparam int unsigned BIT_JK_RESUME = 5;
	localparam int unsigned BIT_BDISCONNECT_ACONNECT_EVENT = 6;
	localparam int unsigned BIT_SESSION_END = 7;
	localparam int unsigned BIT_LONG_SE0 = 8;
	localparam int unsigned BIT_TIMER_EXPIRED = 9;

	// Writable masks and the status read mask; reserved bits read zero
	localparam logic [REG_W-1:0] LATCH_MASK = 16'h03ff;
	localparam logic [REG_W-1:0] FALL_MASK = 16'h019b;
	localparam logic [REG_W-1:0] RISE_MASK = 16'h03ff;
	localparam logic [REG_W-1:0] STATUS_MASK = 16'h019f;
	localparam logic [REG_W-1:0] REG_RESET = 16'h0000;

	// SE0 qualification time
	localparam int unsigned CLOCK_HZ = 20_000_000;
	localparam int unsigned SE0_MIN_US = 2000;
	localparam int unsigned SE0_CYCLES = (CLOCK_HZ / 1_000_000) * SE0_MIN_US;
	localparam int unsigned SE0_CNT_W = 16;
	localparam logic [SE0_CNT_W-1:0] SE0_CNT_ZERO = 16'h0000;

	// Timer control word: bit 0 is the run bit
	localparam int unsigned TIMER_RUN_POS = 0;

	typedef struct packed {
		logic vbus_valid_event;
		logic session_valid_event;
		logic dplus_session_request;
		logic role_sense_pin;
		logic remote_connect_event;
		logic jk_resume_event;
		logic bdisconnect_aconnect_event;
		logic session_end_low_vbus;
		logic bus_se0;
		logic b_idle_state;
	} otg_cond_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [REG_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

endpackage

// *** otg_edge_interrupt_latch.sv ***
// OTG edge interrupt latch: condition synchronisers, edge detection, latch and enables.
// Assumes raw OTG conditions arrive asynchronously and the timer expiry pulse is synchronous.
`timescale 1ns/1ns
`default_nettype none

module otg_edge_interrupt_latch
	import otg_irq_pkg::*;
#(
	parameter int unsigned SE0_HOLD_CYCLES = SE0_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire otg_cond_s cond_raw,
	input wire logic timer_expired_event,
	input wire reg_req_s req,
	output logic [REG_W-1:0] rdata,
	output logic timer_run_bit,
	output logic irq
);

	typedef struct packed {
		otg_cond_s sync1;
		otg_cond_s sync2;
		logic [REG_W-1:0] level_prev;
		logic level_valid;
		logic [1:0] fill;
		logic [SE0_CNT_W-1:0] se0_cnt;
		logic se0_long;
		logic [REG_W-1:0] latch;
		logic [REG_W-1:0] fall_en;
		logic [REG_W-1:0] rise_en;
		logic timer_run;
		logic [REG_W-1:0] rdata;
		logic irq;
	} state_s;

	state_s q, d;

	// Applies set/clear alias writes to a register
	function automatic logic [REG_W-1:0] set_clr(
		input logic [REG_W-1:0] cur,
		input logic [REG_W-1:0] wdata,
		input logic is_set,
		input logic is_clr,
		input logic [REG_W-1:0] mask
	);
		logic [REG_W-1:0] r;
		r = cur;
		if (is_set) begin
			r = r | (wdata & mask);
		end
		if (is_clr) begin
			r = r & ~wdata;
		end
		return r & mask;
	endfunction

	logic [REG_W-1:0] level;
	logic [REG_W-1:0] rise_evt;
	logic [REG_W-1:0] fall_evt;
	logic [REG_W-1:0] hits;
	logic se0_qual;

	always_comb begin
		d = q;
		level = REG_RESET;
		rise_evt = REG_RESET;
		fall_evt = REG_RESET;
		hits = REG_RESET;
		se0_qual = 1'b0;

		// Two-stage synchronisers for every raw condition
		d.sync1 = cond_raw;
		d.sync2 = q.sync1;

		// Long SE0 qualifier, counted only in B-idle
		if (q.sync2.bus_se0 && q.sync2.b_idle_state) begin
			if (q.se0_cnt < SE0_HOLD_CYCLES[SE0_CNT_W-1:0]) begin
				d.se0_cnt = q.se0_cnt + 1'b1;
			end
		end else begin
			d.se0_cnt = SE0_CNT_ZERO;
		end
		se0_qual = (q.se0_cnt >= SE0_HOLD_CYCLES[SE0_CNT_W-1:0]);
		// Stays high until SE0 ends so the fall edge marks exit from a long SE0
		if (!q.sync2.bus_se0) begin
			d.se0_long = 1'b0;
		end else if (se0_qual) begin
			d.se0_long = 1'b1;
		end

		// Live levels, also the status register view
		level[BIT_VBUS_VALID] = q.sync2.vbus_valid_event;
		level[BIT_SESSION_VALID] = q.sync2.session_valid_event;
		level[BIT_DPLUS_SRP] = q.sync2.dplus_session_request;
		level[BIT_ROLE_SENSE] = q.sync2.role_sense_pin;
		level[BIT_REMOTE_CONNECT] = q.sync2.remote_connect_event;
		level[BIT_JK_RESUME] = q.sync2.jk_resume_event;
		level[BIT_BDISCONNECT_ACONNECT_EVENT] = q.sync2.bdisconnect_aconnect_event;
		level[BIT_SESSION_END] = q.sync2.session_end_low_vbus;
		level[BIT_LONG_SE0] = q.se0_long;
		d.level_prev = level;
		// Synchronisers reset low, so a pin already high would look like a rise
		d.fill = {q.fill[0], 1'b1};
		d.level_valid = q.fill[1];

		// Edge detection starts once the history holds a real sample
		if (q.level_valid) begin
			rise_evt = level & ~q.level_prev;
			fall_evt = ~level & q.level_prev;
		end
		rise_evt[BIT_TIMER_EXPIRED] = timer_expired_event & q.timer_run;

		hits = ((rise_evt & q.rise_en & RISE_MASK)
			| (fall_evt & q.fall_en & FALL_MASK)) & LATCH_MASK;

		// Register writes
		if (req.wr) begin
			d.latch = set_clr(q.latch, req.wdata, req.addr == LATCH_SET_ADDR,
				req.addr == LATCH_CLR_ADDR, LATCH_MASK);
			d.fall_en = set_clr(q.fall_en, req.wdata, req.addr == FALL_SET_ADDR,
				req.addr == FALL_CLR_ADDR, FALL_MASK);
			d.rise_en = set_clr(q.rise_en, req.wdata, req.addr == RISE_SET_ADDR,
				req.addr == RISE_CLR_ADDR, RISE_MASK);
			if (req.addr == TIMER_CTRL_ADDR) begin
				d.timer_run = req.wdata[TIMER_RUN_POS];
			end
		end
		// Hardware set wins over a same-cycle clear
		d.latch = d.latch | hits;
		if (timer_expired_event && q.timer_run) begin
			d.timer_run = 1'b0;
		end

		// Read data one cycle after the strobe; unmapped reads return zero
		d.rdata = REG_RESET;
		if (req.rd) begin
			case (req.addr)
				STATUS_ADDR: d.rdata = level & STATUS_MASK;
				LATCH_SET_ADDR, LATCH_CLR_ADDR: d.rdata = q.latch;
				FALL_SET_ADDR, FALL_CLR_ADDR: d.rdata = q.fall_en;
				RISE_SET_ADDR, RISE_CLR_ADDR: d.rdata = q.rise_en;
				TIMER_CTRL_ADDR: d.rdata = {{(REG_W-1){1'b0}}, q.timer_run};
				default: d.rdata = REG_RESET;
			endcase
		end

		d.irq = |d.latch;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rdata = q.rdata;
	assign timer_run_bit = q.timer_run;
	assign irq = q.irq;

endmodule

`default_nettype wire

// *** otg_irq_chk.sv ***
// Concurrent checks on the OTG edge interrupt latch, bound to its top ports.
// Assumes a single clock domain and the package register map.
`timescale 1ns/1ns
`default_nettype none
module otg_irq_chk
	import otg_irq_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire otg_cond_s cond_raw,
	input wire logic timer_expired_event,
	input wire reg_req_s req,
	input wire logic [REG_W-1:0] rdata,
	input wire logic timer_run_bit,
	input wire logic irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_rd(a);
		req.rd && req.addr == a;
	endsequence
	sequence s_wr(a, v);
		req.wr && req.addr == a && req.wdata == v;
	endsequence
	chk_rdata_idle: assert property (!$past(req.rd) |-> rdata == 16'h0000)
		else $error("read data present without a read");
	chk_latch_irq: assert property (s_rd(LATCH_SET_ADDR) |=> (rdata != 16'h0000) == $past(irq))
		else $error("irq disagrees with latch contents");
	chk_status_mask: assert property (s_rd(STATUS_ADDR) |=> (rdata & ~STATUS_MASK) == 16'h0000)
		else $error("status reserved bits set");
	chk_fall_mask: assert property (s_rd(FALL_SET_ADDR) |=> (rdata & ~FALL_MASK) == 16'h0000)
		else $error("falling enable reserved bits set");
	chk_unmapped_read: assert property (s_rd(12'h037a) |=> rdata == 16'h0000)
		else $error("unmapped read not zero");
	chk_rise_clear: assert property (s_wr(RISE_CLR_ADDR, RISE_MASK) ##1 s_rd(RISE_SET_ADDR) |=> rdata == 16'h0000)
		else $error("rising enable not cleared");
	chk_irq_hold: assert property (irq && !(req.wr && req.addr == LATCH_CLR_ADDR) |=> irq)
		else $error("irq dropped without a clear");
	chk_timer_expire: assert property (timer_run_bit && timer_expired_event
		&& !(req.wr && req.addr == TIMER_CTRL_ADDR) |=> !timer_run_bit)
		else $error("run bit kept after expiry");
endmodule
bind otg_edge_interrupt_latch otg_irq_chk chk_i (.clock(clock), .rst_n(rst_n),
	.cond_raw(cond_raw), .timer_expired_event(timer_expired_event), .req(req),
	.rdata(rdata), .timer_run_bit(timer_run_bit), .irq(irq));
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the OTG edge interrupt latch over its register port.
// Assumes a shortened long-SE0 count of 20 cycles.
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import otg_irq_pkg::*;
;
	`define CK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
		$display("ERROR %0t got %h exp %h", $time, a, b); end end
	logic clock = 0;
	logic rst_n = 0;
	otg_cond_s cond_raw = '0;
	logic timer_expired_event = 0;
	reg_req_s req = '0;
	logic [REG_W-1:0] rdata, d;
	logic timer_run_bit, irq;
	int num_errors = 0, n_tests = 0, cyc = 0;
	always #25 clock = ~clock;
	otg_edge_interrupt_latch #(.SE0_HOLD_CYCLES(20)) dut (.clock(clock), .rst_n(rst_n),
		.cond_raw(cond_raw), .timer_expired_event(timer_expired_event), .req(req),
		.rdata(rdata), .timer_run_bit(timer_run_bit), .irq(irq));
	task automatic results();
		if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 2000) begin
			num_errors++;
			results();
		end
	end
	// A write leaves its strobe up; the next call or tick replaces or lowers it
	task automatic tick(input int n);
		if (req.wr) begin
			req.wr <= 1'b0;
		end
		repeat (n) @(posedge clock);
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] v);
		req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
	endtask
	// Read data stand in the cycle after the strobe; sampled before the next update
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e);
		req <= '{addr: a, wdata: REG_RESET, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		req.rd <= 1'b0;
		@(posedge clock);
		`CK(rdata, e)
	endtask
	initial begin
		tick(12);
		rst_n <= 1'b1;
		tick(2);
		rd(LATCH_SET_ADDR, 16'h0000);
		rd(FALL_CLR_ADDR, 16'h0000);
		rd(RISE_SET_ADDR, 16'h0000);
		wr(RISE_SET_ADDR, RISE_MASK);
		rd(RISE_CLR_ADDR, RISE_MASK);
		wr(FALL_SET_ADDR, FALL_MASK);
		wr(FALL_CLR_ADDR, 16'h0003);
		rd(FALL_SET_ADDR, 16'h0198);
		for (int i = 0; i < 8; i++) begin
			cond_raw[9-i] <= 1'b1;
			tick(4);
			rd(LATCH_CLR_ADDR, REG_W'(1 << i));
			`CK(irq, 1'b1)
			wr(LATCH_CLR_ADDR, REG_W'(1 << i));
		end
		rd(STATUS_ADDR, 16'h009f);
		`CK(irq, 1'b0)
		wr(FALL_SET_ADDR, 16'h0003);
		for (int i = 0; i < 8; i++) begin
			cond_raw[9-i] <= 1'b0;
			tick(4);
			d = FALL_MASK[i] ? REG_W'(1 << i) : 16'h0000;
			rd(LATCH_SET_ADDR, d);
			wr(LATCH_CLR_ADDR, d);
		end
		wr(TIMER_CTRL_ADDR, 16'h0001);
		timer_expired_event <= 1'b1;
		tick(1);
		timer_expired_event <= 1'b0;
		rd(LATCH_SET_ADDR, 16'h0200);
		rd(TIMER_CTRL_ADDR, 16'h0000);
		`CK(timer_run_bit, 1'b0)
		wr(LATCH_CLR_ADDR, 16'h0200);
		timer_expired_event <= 1'b1;
		tick(1);
		timer_expired_event <= 1'b0;
		rd(LATCH_SET_ADDR, 16'h0000);
		wr(RISE_CLR_ADDR, RISE_MASK);
		rd(RISE_SET_ADDR, 16'h0000);
		cond_raw.vbus_valid_event <= 1'b1;
		tick(4);
		rd(LATCH_SET_ADDR, 16'h0000);
		wr(RISE_SET_ADDR, 16'h0100);
		cond_raw.bus_se0 <= 1'b1;
		cond_raw.b_idle_state <= 1'b1;
		tick(30);
		rd(STATUS_ADDR, 16'h0101);
		rd(LATCH_SET_ADDR, 16'h0100);
		wr(LATCH_CLR_ADDR, 16'h0100);
		cond_raw.bus_se0 <= 1'b0;
		tick(4);
		rd(LATCH_SET_ADDR, 16'h0100);
		rd(12'h037a, 16'h0000);
		results();
	end
endmodule
`default_nettype wire
